/* sim/group_desc_props.sv */
// checker on the addressing block ports
// assumes bind into group_desc_addressing, one clock
`timescale 1ns/100ps
`default_nettype none
module group_desc_props (
  input wire logic                        i_core_clk,
  input wire logic                        i_rst_n,
  input wire logic [31:0]                 i_func0_bar,
  input wire group_desc_pkg::slv_wr_type  i_slv_wr,
  input wire logic                        o_func0_hit,
  input wire logic                        i_ptr_valid,
  input wire group_desc_pkg::ptr_req_type i_ptr_req,
  input wire logic                        o_ptr_ready,
  input wire logic                        o_ptr_rvalid,
  input wire logic [31:0]                 o_ptr_rdata,
  input wire logic                        o_mrd_valid,
  input wire logic [31:0]                 o_mrd_addr,
  input wire logic                        i_mrd_rvalid,
  input wire logic [31:0]                 i_mrd_rdata,
  input wire logic                        i_mwr_valid,
  input wire group_desc_pkg::mw_kind_type i_mwr_kind,
  input wire logic                        o_mwr_grant,
  input wire logic                        o_mwr_refused,
  input wire logic                        o_fetch_busy
);
  // ----------------------------------------------------------------
  // fetch word counter and properties
  // ----------------------------------------------------------------
  logic [8:0] cnt_q;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) cnt_q <= 9'h000;
    else if (!o_fetch_busy) cnt_q <= 9'h000;
    else if (i_mrd_rvalid) cnt_q <= cnt_q + 9'h001;
  end
  sequence s_ptr_take;
    i_ptr_valid && o_ptr_ready;
  endsequence
  sequence s_fetch_step;
    o_fetch_busy && i_mrd_rvalid && cnt_q != group_desc_pkg::IMG_LAST;
  endsequence
  sequence s_srv_wr;
    o_func0_hit && i_slv_wr.addr[19:14] == group_desc_pkg::WIN_HI_ZERO
      && i_slv_wr.addr[10:0] == group_desc_pkg::REG_SRV_REQ;
  endsequence
  AST_PTR_ADDR: assert property (
    s_ptr_take |=> o_mrd_valid && o_mrd_addr[10:0] == {2'h0, $past(i_ptr_req.kind), $past(i_ptr_req.chan), 2'h0})
    else $error("pointer read address wrong");
  AST_PTR_DATA: assert property (
    o_ptr_rvalid |-> $past(i_mrd_rvalid) && o_ptr_rdata == $past(i_mrd_rdata))
    else $error("pointer word not from memory");
  AST_FETCH_START: assert property (
    $rose(o_fetch_busy) |-> o_mrd_valid && o_mrd_addr[10:0] == group_desc_pkg::OFF_TX_TSMAP)
    else $error("fetch start offset wrong");
  AST_FETCH_STEP: assert property (
    s_fetch_step |=> o_mrd_valid && o_mrd_addr == $past(o_mrd_addr) + 32'h0000_0004)
    else $error("fetch address not ascending");
  AST_FETCH_LEN: assert property (
    $fell(o_fetch_busy) |-> cnt_q == group_desc_pkg::IMG_LAST + 9'h001)
    else $error("fetch word count wrong");
  AST_FETCH_STALL: assert property (
    o_fetch_busy |-> !o_ptr_ready)
    else $error("pointer taken during fetch");
  AST_SRV_STALL: assert property (
    s_srv_wr |=> !o_ptr_ready)
    else $error("pointer taken with service request pending");
  AST_MWR_GRANT: assert property (
    o_mwr_grant == (i_mwr_valid && i_mwr_kind <= group_desc_pkg::MW_RX_DATA))
    else $error("master write grant wrong");
  AST_MWR_REFUSE: assert property (
    i_mwr_valid && i_mwr_kind > group_desc_pkg::MW_RX_DATA |=> o_mwr_refused)
    else $error("master write not refused");
  AST_F0_HIT: assert property (
    o_func0_hit == (i_slv_wr.valid && i_slv_wr.addr[31:20] == i_func0_bar[31:20]))
    else $error("window hit wrong");
endmodule
bind group_desc_addressing group_desc_props u_props (
  .i_core_clk, .i_rst_n, .i_func0_bar, .i_slv_wr, .o_func0_hit, .i_ptr_valid, .i_ptr_req, .o_ptr_ready,
  .o_ptr_rvalid, .o_ptr_rdata, .o_mrd_valid, .o_mrd_addr, .i_mrd_rvalid, .i_mrd_rdata, .i_mwr_valid,
  .i_mwr_kind, .o_mwr_grant, .o_mwr_refused, .o_fetch_busy);
`default_nettype wire

/* sim/shared_mem_model.sv */
// shared memory model answering master reads
// assumes one read outstanding; word is address xor salt
`timescale 1ns/100ps
`default_nettype none
module shared_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_slow,
  input  wire logic [31:0] i_salt,
  input  wire logic        i_rd_valid,
  input  wire logic [31:0] i_rd_addr,
  output logic             o_rd_ready,
  output logic             o_rd_rvalid,
  output logic [31:0]      o_rd_rdata
);
  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  logic go_q;
  // live image on every read, host keeps contents
  assign o_rd_ready = i_rd_valid && go_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      go_q        <= 1'b1;
      o_rd_rvalid <= 1'b0;
      o_rd_rdata  <= 32'h0000_0000;
    end else begin
      go_q        <= i_slow ? ~go_q : 1'b1;
      o_rd_rvalid <= o_rd_ready;
      o_rd_rdata  <= o_rd_ready ? (i_rd_addr ^ i_salt) : ~o_rd_rdata;
    end
  end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// testbench for group descriptor addressing
// assumes shared_mem_model on the master read side
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // signals, design and memory
  // ----------------------------------------------------------------
  logic                        clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic [31:0]                 bar0 = 32'h0240_0000;
  logic [31:0]                 bar1 = 32'h0340_0000;
  group_desc_pkg::slv_wr_type  slv = '0;
  logic                        pv = 1'b0;
  group_desc_pkg::ptr_req_type preq = '0;
  logic                        mwv = 1'b0;
  group_desc_pkg::mw_kind_type mwk = group_desc_pkg::MW_MSG_PTR;
  logic [2:0]                  rdg = 3'h0;
  logic [8:0]                  rdw = 9'h000;
  logic                        slow = 1'b0;
  logic [31:0]                 salt = 32'h0000_0000;
  logic [31:0]                 base [2];
  logic                        f0h, f1h, prdy, prv, mvld, mrdy, mrv, mwg, mwr, busy;
  logic [31:0]                 prd, maddr, mrd, imgd, gcfg;
  int                          error_cnt = 0;
  int                          n_checks = 0;
  always #2 clk = ~clk;
  group_desc_addressing u_dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_func0_bar(bar0), .i_func1_bar(bar1), .i_slv_wr(slv),
    .o_func0_hit(f0h), .o_func1_hit(f1h), .i_ptr_valid(pv), .i_ptr_req(preq), .o_ptr_ready(prdy),
    .o_ptr_rvalid(prv), .o_ptr_rdata(prd), .o_mrd_valid(mvld), .o_mrd_addr(maddr), .i_mrd_ready(mrdy),
    .i_mrd_rvalid(mrv), .i_mrd_rdata(mrd), .i_mwr_valid(mwv), .i_mwr_kind(mwk), .o_mwr_grant(mwg),
    .o_mwr_refused(mwr), .i_img_rd_group(rdg), .i_img_rd_word(rdw), .o_img_rd_data(imgd),
    .o_global_cfg(gcfg), .o_fetch_busy(busy));
  shared_mem_model u_mem (
    .i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_salt(salt), .i_rd_valid(mvld), .i_rd_addr(maddr),
    .o_rd_ready(mrdy), .o_rd_rvalid(mrv), .o_rd_rdata(mrd));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic swr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    slv = '{1'b1, a, d};
    #1;
    check(32'(f0h), 32'(a[31:20] == bar0[31:20]));
    check(32'(f1h), 32'(a[31:20] == bar1[31:20]));
    @(negedge clk);
    slv.valid = 1'b0;
  endtask
  task automatic ptr(input logic g, input logic [1:0] k, input logic [4:0] c);
    logic [31:0] a;
    a = (base[g] & 32'hffff_f800) + {23'h0, k, c, 2'h0};
    @(negedge clk);
    pv = 1'b1;
    preq = '{{2'h0, g}, c, group_desc_pkg::ptr_kind_type'(k)};
    for (int i = 0; i < 50 && prdy !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    pv = 1'b0;
    check(maddr, a);
    for (int i = 0; i < 20 && prv !== 1'b1; i++) @(negedge clk);
    check(32'(prv), 32'h1);
    check(prd, a ^ salt);
  endtask
  task automatic t_ptr;
    base[0] = 32'h0090_0000;
    base[1] = 32'h0090_0805;
    swr(bar0, base[0]);
    swr(bar0 + 32'h0000_0800, base[1]);
    swr(bar1, 32'h0bad_0000);
    for (int k = 0; k < 4; k++) begin
      ptr(1'b1, 2'(k), 5'h00);
      ptr(1'b1, 2'(k), 5'h1f);
    end
    ptr(1'b0, 2'h0, 5'h05);
  endtask
  task automatic t_nocache;
    slow = 1'b1;
    salt = 32'h00a5_0000;
    ptr(1'b1, 2'h3, 5'h1f);
  endtask
  task automatic t_mwr;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      mwv = 1'b1;
      mwk = group_desc_pkg::mw_kind_type'(k);
      #1;
      check(32'(mwg), 32'(k < 3));
      @(negedge clk);
      check(32'(mwr), 32'(k > 2));
      mwv = 1'b0;
    end
  endtask
  task automatic t_fetch;
    int wl [10] = '{0, 32, 96, 128, 160, 224, 256, 257, 261, 262};
    logic [31:0] b;
    b = (base[1] & 32'hffff_f800) + 32'h0000_0200;
    swr(bar0 + 32'h0000_0808, 32'h0000_0000);
    for (int i = 0; i < 10 && busy !== 1'b1; i++) @(negedge clk);
    check(32'(prdy), 32'h0);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
    check(gcfg, (b + 32'h0000_0400) ^ salt);
    rdg = 3'h1;
    foreach (wl[i]) begin
      rdw = 9'(wl[i]);
      @(negedge clk);
      check(imgd, (b + 32'(wl[i] * 4)) ^ salt);
    end
    rdw = 9'h107;
    @(negedge clk);
    check(imgd, 32'h0000_0000);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_ptr();
    t_nocache();
    t_mwr();
    t_fetch();
    give_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire

/* src/desc_addr_gen.sv */
// address of one word inside a group structure
// assumes a 2 kB aligned base; low bits of base are ignored
`timescale 1ns/100ps
`default_nettype none
module desc_addr_gen (
  input  wire logic [31:0] i_base,
  input  wire logic [10:0] i_offset,
  input  wire logic [8:0]  i_word,
  output logic      [31:0] o_addr
);
  // offsets added straight onto the aligned base
  assign o_addr = (i_base & group_desc_pkg::BASE_ALIGN_MASK) + {21'h000000, i_offset}
                + {21'h000000, i_word, 2'h0}; // [R6]
endmodule
`default_nettype wire

/* src/group_desc_addressing.sv */
// group base pointers, service request fetch and pointer address generation
// assumes pci slave decode, master read and master write engines on i_core_clk
`timescale 1ns/100ps
`default_nettype none
module group_desc_addressing #(
  parameter int NUM_GROUPS = 8
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst_n,
  input  wire logic [31:0]                 i_func0_bar,
  input  wire logic [31:0]                 i_func1_bar,
  input  wire group_desc_pkg::slv_wr_type  i_slv_wr,
  output logic                             o_func0_hit,
  output logic                             o_func1_hit,
  input  wire logic                        i_ptr_valid,
  input  wire group_desc_pkg::ptr_req_type i_ptr_req,
  output logic                             o_ptr_ready,
  output logic                             o_ptr_rvalid,
  output logic [31:0]                      o_ptr_rdata,
  output logic                             o_mrd_valid,
  output logic [31:0]                      o_mrd_addr,
  input  wire logic                        i_mrd_ready,
  input  wire logic                        i_mrd_rvalid,
  input  wire logic [31:0]                 i_mrd_rdata,
  input  wire logic                        i_mwr_valid,
  input  wire group_desc_pkg::mw_kind_type i_mwr_kind,
  output logic                             o_mwr_grant,
  output logic                             o_mwr_refused,
  input  wire logic [2:0]                  i_img_rd_group,
  input  wire logic [8:0]                  i_img_rd_word,
  output logic [31:0]                      o_img_rd_data,
  output logic [31:0]                      o_global_cfg,
  output logic                             o_fetch_busy
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic win_hit(input logic [31:0] addr, input logic [31:0] bar);
    win_hit = (addr[31:group_desc_pkg::WIN_SHIFT] == bar[31:group_desc_pkg::WIN_SHIFT]);
  endfunction

  function automatic logic [10:0] kind_off(input group_desc_pkg::ptr_kind_type k);
    case (k)
      group_desc_pkg::PK_TX_HEAD: kind_off = group_desc_pkg::OFF_TX_HEAD;
      group_desc_pkg::PK_TX_MSG:  kind_off = group_desc_pkg::OFF_TX_MSG;
      group_desc_pkg::PK_RX_HEAD: kind_off = group_desc_pkg::OFF_RX_HEAD;
      default:                    kind_off = group_desc_pkg::OFF_RX_MSG;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // window decode
  // ----------------------------------------------------------------
  logic [19:0] win_off;
  logic [2:0]  wr_group;
  logic [10:0] wr_reg;
  logic        wr_ok;

  assign o_func0_hit = i_slv_wr.valid && win_hit(i_slv_wr.addr, i_func0_bar); // [R8]
  assign o_func1_hit = i_slv_wr.valid && win_hit(i_slv_wr.addr, i_func1_bar); // [R8]
  assign win_off     = i_slv_wr.addr[19:0];
  assign wr_group    = win_off[13:group_desc_pkg::GROUP_SHIFT];
  assign wr_reg      = win_off[10:0];
  assign wr_ok       = o_func0_hit && (win_off[19:14] == group_desc_pkg::WIN_HI_ZERO)
                     && (32'(wr_group) < NUM_GROUPS);

  // ----------------------------------------------------------------
  // group base pointers
  // ----------------------------------------------------------------
  logic [31:0] base_q [NUM_GROUPS];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        base_q[g] <= 32'h0000_0000;
      end
    end else if (wr_ok && wr_reg == group_desc_pkg::REG_BASE_PTR) begin
      base_q[wr_group] <= i_slv_wr.data; // [R7]
    end
  end

  // ----------------------------------------------------------------
  // service requests
  // ----------------------------------------------------------------
  logic [NUM_GROUPS-1:0] srv_pend_q;
  logic [NUM_GROUPS-1:0] srv_set;
  logic [NUM_GROUPS-1:0] srv_clr;
  logic [2:0]            srv_pick;
  logic                  srv_any;

  always_comb begin
    srv_set  = '0;
    srv_pick = 3'h0;
    srv_any  = 1'b0;
    if (wr_ok && wr_reg == group_desc_pkg::REG_SRV_REQ) begin
      srv_set[wr_group] = 1'b1;
    end
    for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
      if (srv_pend_q[g]) begin
        srv_pick = 3'(g);
        srv_any  = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      srv_pend_q <= '0;
    end else begin
      srv_pend_q <= (srv_pend_q & ~srv_clr) | srv_set; // [R12]
    end
  end

  // ----------------------------------------------------------------
  // master read sequencer
  // ----------------------------------------------------------------
  group_desc_pkg::fsm_type state_q;
  group_desc_pkg::fsm_type state_d;
  logic [2:0]  fgrp_q;
  logic [8:0]  word_q;
  logic [31:0] gen_base;
  logic [10:0] gen_off;
  logic [8:0]  gen_word;
  logic [31:0] gen_addr;
  logic        load_addr;
  logic        take_ptr;
  logic        fetch_start;
  logic        fetch_word;

  assign fetch_start  = (state_q == group_desc_pkg::ST_IDLE) && srv_any;
  assign take_ptr     = (state_q == group_desc_pkg::ST_IDLE) && !srv_any && i_ptr_valid;
  assign fetch_word   = (state_q == group_desc_pkg::ST_FWAIT) && i_mrd_rvalid;
  assign o_ptr_ready  = (state_q == group_desc_pkg::ST_IDLE) && !srv_any;
  assign o_mrd_valid  = (state_q == group_desc_pkg::ST_PREQ) || (state_q == group_desc_pkg::ST_FREQ);
  assign o_fetch_busy = (state_q == group_desc_pkg::ST_FREQ) || (state_q == group_desc_pkg::ST_FWAIT);
  assign load_addr    = fetch_start || take_ptr || (fetch_word && word_q != group_desc_pkg::IMG_LAST);

  always_comb begin
    srv_clr = '0;
    if (fetch_start) begin
      srv_clr[srv_pick] = 1'b1;
    end
  end

  always_comb begin
    gen_base = base_q[fgrp_q];
    gen_off  = group_desc_pkg::OFF_TX_TSMAP; // [R3]
    gen_word = word_q + 9'h001;
    if (fetch_start) begin
      gen_base = base_q[srv_pick];
      gen_word = 9'h000;
    end else if (take_ptr) begin
      gen_base = base_q[i_ptr_req.group];
      gen_off  = kind_off(i_ptr_req.kind); // [R2]
      gen_word = {4'h0, i_ptr_req.chan}; // [R13]
    end
  end

  desc_addr_gen u_addr_gen (
    .i_base   (gen_base),
    .i_offset (gen_off),
    .i_word   (gen_word),
    .o_addr   (gen_addr)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      group_desc_pkg::ST_IDLE: begin
        if (fetch_start) begin
          state_d = group_desc_pkg::ST_FREQ;
        end else if (take_ptr) begin
          state_d = group_desc_pkg::ST_PREQ; // [R1]
        end
      end
      group_desc_pkg::ST_PREQ: begin
        if (i_mrd_ready) begin
          state_d = group_desc_pkg::ST_PWAIT;
        end
      end
      group_desc_pkg::ST_PWAIT: begin
        if (i_mrd_rvalid) begin
          state_d = group_desc_pkg::ST_IDLE;
        end
      end
      group_desc_pkg::ST_FREQ: begin
        if (i_mrd_ready) begin
          state_d = group_desc_pkg::ST_FWAIT;
        end
      end
      group_desc_pkg::ST_FWAIT: begin
        if (i_mrd_rvalid) begin
          state_d = (word_q == group_desc_pkg::IMG_LAST) ? group_desc_pkg::ST_IDLE : group_desc_pkg::ST_FREQ;
        end
      end
      default: begin
        state_d = group_desc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= group_desc_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mrd_addr <= 32'h0000_0000;
    end else if (load_addr) begin
      o_mrd_addr <= gen_addr;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fgrp_q <= 3'h0;
      word_q <= 9'h000;
    end else if (fetch_start) begin
      fgrp_q <= srv_pick;
      word_q <= 9'h000;
    end else if (fetch_word && word_q != group_desc_pkg::IMG_LAST) begin
      word_q <= word_q + 9'h001; // [R4]
    end
  end

  // ----------------------------------------------------------------
  // pointer read return, o_ptr_rdata held until the next answer, never reused
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ptr_rvalid <= 1'b0;
      o_ptr_rdata  <= 32'h0000_0000;
    end else begin
      o_ptr_rvalid <= (state_q == group_desc_pkg::ST_PWAIT) && i_mrd_rvalid; // [R1]
      if ((state_q == group_desc_pkg::ST_PWAIT) && i_mrd_rvalid) begin
        o_ptr_rdata <= i_mrd_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // internal image of each group
  // ----------------------------------------------------------------
  logic [31:0] img_mem [NUM_GROUPS][group_desc_pkg::IMG_WORDS];

  always_ff @(posedge i_core_clk) begin
    if (fetch_word) begin
      img_mem[fgrp_q][word_q] <= i_mrd_rdata; // [R5]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_img_rd_data <= 32'h0000_0000;
    end else if (32'(i_img_rd_group) < NUM_GROUPS && i_img_rd_word <= group_desc_pkg::IMG_LAST) begin
      o_img_rd_data <= img_mem[i_img_rd_group][i_img_rd_word];
    end else begin
      o_img_rd_data <= 32'h0000_0000;
    end
  end

  // one device-wide copy, whichever group fetch delivered it last
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_global_cfg <= 32'h0000_0000;
    end else if (fetch_word && word_q == group_desc_pkg::IMG_GLOBAL_IX) begin
      o_global_cfg <= i_mrd_rdata; // [R11]
    end
  end

  // ----------------------------------------------------------------
  // master write ownership guard
  // ----------------------------------------------------------------
  logic mwr_allowed;

  assign mwr_allowed = (i_mwr_kind == group_desc_pkg::MW_MSG_PTR)
                    || (i_mwr_kind == group_desc_pkg::MW_BUF_STATUS)
                    || (i_mwr_kind == group_desc_pkg::MW_RX_DATA); // [R9]
  assign o_mwr_grant = i_mwr_valid && mwr_allowed;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mwr_refused <= 1'b0;
    end else begin
      o_mwr_refused <= i_mwr_valid && !mwr_allowed; // [R9]
    end
  end

endmodule
`default_nettype wire

/* src/group_desc_pkg.sv */
// group descriptor addressing: constants, types and offsets
// assumes one pci clock domain; sources sit on the same clock
// What this block does
// [R1] head and message pointers live in shared memory only; fetched on every use
// [R2] pointer areas at group offsets 0, 080h, 100h, 180h, 128 bytes each
// [R3] tx time slot map 200h, tx subchannel map 280h, tx channel table 380h
// [R4] rx time slot map 400h, rx subchannel map 480h, rx channel table 580h
// [R5] image from 200h to 61Bh has internal copies; group descriptors at 600h-618h
// [R6] host allocates 1564 bytes per group, base aligned to 2 kB
// [R7] host loads each group base pointer by slave memory write; device accepts it
// [R8] two functions each decode a 1 MB window set up by configuration
// [R9] master writes only message pointers, buffer status and receive data buffers
// [R10] host allocates, frees and maintains all shared memory descriptors and buffers
// [R11] global descriptor configuration applies to the whole device
// [R12] service request write makes device fetch group image into internal registers
// [R13] pointer slot is one word indexed by channel; 32 channels per area
package group_desc_pkg;

  // ----------------------------------------------------------------
  // group structure offsets
  // ----------------------------------------------------------------
  localparam logic [10:0] OFF_TX_HEAD   = 11'h000;
  localparam logic [10:0] OFF_TX_MSG    = 11'h080;
  localparam logic [10:0] OFF_RX_HEAD   = 11'h100;
  localparam logic [10:0] OFF_RX_MSG    = 11'h180;
  localparam logic [10:0] OFF_TX_TSMAP  = 11'h200;
  localparam logic [10:0] OFF_TX_SUBMAP = 11'h280;
  localparam logic [10:0] OFF_TX_CHCFG  = 11'h380;
  localparam logic [10:0] OFF_RX_TSMAP  = 11'h400;
  localparam logic [10:0] OFF_RX_SUBMAP = 11'h480;
  localparam logic [10:0] OFF_RX_CHCFG  = 11'h580;
  localparam logic [10:0] OFF_GLOBAL    = 11'h600;
  localparam logic [10:0] OFF_INTQ      = 11'h604;
  localparam logic [10:0] OFF_GRP_CFG   = 11'h60c;
  localparam logic [10:0] OFF_MEM_PROT  = 11'h610;
  localparam logic [10:0] OFF_MSG_LEN   = 11'h614;
  localparam logic [10:0] OFF_PORT_CFG  = 11'h618;
  localparam logic [10:0] OFF_IMG_END   = 11'h61c;
  localparam int          GROUP_BYTES   = 1564;

  // image words from the time slot map up to the end of the structure
  localparam int          IMG_WORDS     = (OFF_IMG_END - OFF_TX_TSMAP) / 4;
  localparam logic [8:0]  IMG_LAST      = 9'(IMG_WORDS - 1);
  localparam logic [8:0]  IMG_GLOBAL_IX = 9'((OFF_GLOBAL - OFF_TX_TSMAP) / 4);

  // ----------------------------------------------------------------
  // device register map and windows
  // ----------------------------------------------------------------
  localparam logic [31:0] BASE_ALIGN_MASK = 32'hffff_f800;
  localparam int          GROUP_SHIFT     = 11;
  localparam int          WIN_SHIFT       = 20;
  localparam logic [10:0] REG_BASE_PTR    = 11'h000;
  localparam logic [10:0] REG_SRV_REQ     = 11'h008;
  localparam logic [5:0]  WIN_HI_ZERO     = 6'h00;
  localparam int          CHANS_PER_GROUP = 32;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PK_TX_HEAD = 2'h0,
    PK_TX_MSG  = 2'h1,
    PK_RX_HEAD = 2'h2,
    PK_RX_MSG  = 2'h3
  } ptr_kind_type;

  typedef enum logic [2:0] {
    MW_MSG_PTR    = 3'h0,
    MW_BUF_STATUS = 3'h1,
    MW_RX_DATA    = 3'h2,
    MW_HEAD_PTR   = 3'h3,
    MW_MSG_DESC   = 3'h4,
    MW_CONFIG     = 3'h5,
    MW_TX_DATA    = 3'h6,
    MW_OTHER      = 3'h7
  } mw_kind_type;

  typedef struct packed {
    logic [2:0]   group;
    logic [4:0]   chan;
    ptr_kind_type kind;
  } ptr_req_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } slv_wr_type;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_PREQ  = 5'b00010,
    ST_PWAIT = 5'b00100,
    ST_FREQ  = 5'b01000,
    ST_FWAIT = 5'b10000
  } fsm_type;

endpackage
